// ### core/can_mo_front.sv
// apb front end for two interfaces of message objects
//
// Local design decision: the APB interface to the registers.
`include "can_mo_consts.svh"
`default_nettype none
module can_mo_front #(
  parameter int          NOBJ      = 15,
  parameter logic [7:0]  BITTIME0  = `BITTIME0_1MBIT,
  parameter logic [7:0]  BITTIME1  = `BITTIME1_1MBIT
) (
  input  wire logic                         clock,
  input  wire logic                         reset,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [1:0]                   rx_valid,
  input  wire can_mo_pkg::can_frame_t [1:0] rx_frame,
  output logic [1:0]                        tx_valid,
  output can_mo_pkg::can_frame_t [1:0]      tx_frame,
  input  wire logic [1:0]                   tx_ready,
  output logic [1:0]                        controller_reset,
  output logic                              can_event
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0]             msg_buffer [1:9];
  logic [7:0]             ctrl_regs [2][256];
  logic [31:0]            ident;
  logic [31:0]            result;
  logic [8:0]             creg_sel;
  logic                   cmd_error;
  logic                   event_can;
  logic                   event_if;
  logic [3:0]             event_obj;
  can_mo_pkg::init_state_t init_state;
  logic                   init_if;
  logic [7:0]             init_addr;
  can_mo_pkg::obj_view_t  view [2];
  logic [1:0]             hit;
  logic [3:0]             hit_obj [2];
  logic [1:0]             disable_all;

  // ----------------------------------------
  // bus decode and command fields
  // ----------------------------------------
  logic                   setup;
  logic                   wr;
  logic                   cmd_go;
  logic                   busy;
  logic                   cmd_if;
  logic [3:0]             cmd_obj;
  can_mo_pkg::cmd_op_t    cmd_op;
  logic [3:0]             buf_idx;
  logic                   buf_hit;
  logic [7:0]             len_clip;

  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign busy    = init_state == can_mo_pkg::INIT_WALK;
  assign cmd_if  = pwdata[`CMD_IF_BIT];
  assign cmd_obj = pwdata[3:0];
  assign cmd_op  = can_mo_pkg::cmd_op_t'(pwdata[`CMD_OP_LSB +: 3]);
  // commands while init runs are refused and flagged
  assign cmd_go  = wr && paddr == `REG_CMD && !busy;
  assign buf_hit = paddr >= `REG_BUF_BASE && paddr <= `REG_BUF_LAST && paddr[1:0] == 2'b00;
  assign buf_idx = 4'((paddr - `REG_BUF_BASE) >> 2) + 4'h1;
  // byte count clipped to eight
  assign len_clip = (msg_buffer[`BUF_LEN_ENTRY] > `MAX_DATA_BYTES)
                    ? `MAX_DATA_BYTES : msg_buffer[`BUF_LEN_ENTRY];

  // ----------------------------------------
  // per interface object banks and transmit
  // ----------------------------------------
  for (genvar i = 0; i < 2; i++)
  begin : g_if
    logic is_me;
    assign is_me = cmd_go && cmd_if == 1'(i);

    can_object_bank #(.NOBJ(NOBJ)) u_bank (
      .clock       (clock),
      .reset       (reset),
      .disable_all (disable_all[i]),
      .cfg_write   (is_me && (cmd_op == can_mo_pkg::OP_EN_RX || cmd_op == can_mo_pkg::OP_EN_TX)),
      .cfg_obj     (cmd_obj),
      .cfg_mode    (cmd_op == can_mo_pkg::OP_EN_RX ? can_mo_pkg::OBJ_RX : can_mo_pkg::OBJ_TX),
      .cfg_id      (ident[28:0]),
      .cfg_ext     (ident[`IDENT_EXT_BIT]),
      .rd_obj      (cmd_obj),
      .rd_take     (is_me && cmd_op == can_mo_pkg::OP_READ),
      .rx_valid    (rx_valid[i]),
      .rx_frame    (rx_frame[i]),
      .sel_view    (view[i]),
      .hit         (hit[i]),
      .hit_obj     (hit_obj[i])
    );

    // frame is built from the object and the buffer, held until taken
    always_ff @(posedge clock)
    begin
      if (reset || disable_all[i])
      begin
        tx_valid[i] <= 1'b0;
        tx_frame[i] <= '0;
      end
      else if (tx_valid[i] && tx_ready[i])
      begin
        tx_valid[i] <= 1'b0;
      end
      else if (is_me && cmd_op == can_mo_pkg::OP_TRANSMIT
               && view[i].mode == can_mo_pkg::OBJ_TX && !tx_valid[i])
      begin
        tx_valid[i]      <= 1'b1;
        tx_frame[i].id   <= view[i].id;
        tx_frame[i].ext  <= view[i].ext;
        tx_frame[i].len  <= len_clip[3:0];
        for (int b = 0; b < 8; b++)
          tx_frame[i].data[8*b +: 8] <= (4'(b) < len_clip[3:0]) ? msg_buffer[b + 1] : 8'h00;
      end
    end

    a_tx_enabled: assert property (@(posedge clock) disable iff (reset)
      $rose(tx_valid[i]) |-> $past(view[i].mode) == can_mo_pkg::OBJ_TX
                             && tx_frame[i].id == $past(view[i].id))
      else $error("frame sent from an object not enabled to send");
    a_tx_length: assert property (@(posedge clock) disable iff (reset)
      tx_valid[i] |-> tx_frame[i].len <= 4'h8)
      else $error("frame length above eight");
  end

  // ----------------------------------------
  // identifier holding register and error flag
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
      ident <= '0;
    else if (wr && paddr == `REG_IDENT)
      ident <= pwdata;
  end

  // refused commands set the flag; a new refusal wins over a clear
  always_ff @(posedge clock)
  begin
    if (reset)
      cmd_error <= 1'b0;
    else if (wr && paddr == `REG_CMD && (busy || (cmd_op == can_mo_pkg::OP_TRANSMIT
             && (view[cmd_if].mode != can_mo_pkg::OBJ_TX || tx_valid[cmd_if]))))
      cmd_error <= 1'b1;
    else if (wr && paddr == `REG_STATUS && pwdata[`STAT_ERR_BIT])
      cmd_error <= 1'b0;
  end

  // ----------------------------------------
  // message buffer and read result
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      result <= `NO_MESSAGE;
      for (int n = 1; n <= 9; n++)
        msg_buffer[n] <= 8'h00;
    end
    else if (cmd_go && cmd_op == can_mo_pkg::OP_READ)
    begin
      // a message is handed out once, then reads report nothing new
      if (view[cmd_if].new_data)
      begin
        result <= {3'h0, view[cmd_if].id};
        for (int n = 1; n <= 8; n++)
          msg_buffer[n] <= view[cmd_if].data[8*(n-1) +: 8];
        msg_buffer[`BUF_LEN_ENTRY] <= {4'h0, view[cmd_if].len};
      end
      else
        result <= `NO_MESSAGE;
    end
    else if (wr && buf_hit)
      msg_buffer[buf_idx] <= pwdata[7:0];
  end

  // ----------------------------------------
  // event source selection
  // ----------------------------------------
  // one source at a time, whichever was written last
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      event_can <= 1'b0;
      event_if  <= 1'b0;
      event_obj <= 4'h0;
    end
    else if (cmd_go && cmd_op == can_mo_pkg::OP_EN_EVENT)
    begin
      event_can <= 1'b1;
      event_if  <= cmd_if;
      event_obj <= cmd_obj;
    end
    else if (wr && paddr == `REG_EVENT)
      event_can <= pwdata[0];
  end

  // arrival in the watched object gives a one-cycle event
  always_ff @(posedge clock)
  begin
    if (reset)
      can_event <= 1'b0;
    else
      can_event <= event_can && hit[event_if] && hit_obj[event_if] == event_obj;
  end

  // ----------------------------------------
  // init sequence
  // ----------------------------------------
  function automatic logic [7:0] init_value(input logic [7:0] a);
    if (a >= `CREG_MASK_FIRST && a <= `CREG_MASK_LAST)
      return `MASK_EXACT;
    else if (a == `CREG_BITTIME0)
      return BITTIME0;
    else if (a == `CREG_BITTIME1)
      return BITTIME1;
    else
      return `CREG_CLEAR;
  endfunction

  // walk every controller register of the commanded interface once, starting with a reset pulse
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      init_state  <= can_mo_pkg::INIT_IDLE;
      init_if     <= 1'b0;
      init_addr   <= 8'h00;
      disable_all <= 2'b00;
      controller_reset <= 2'b00;
    end
    else
    begin
      disable_all      <= 2'b00;
      controller_reset <= 2'b00;
      case (init_state)
        can_mo_pkg::INIT_IDLE:
          if (cmd_go && cmd_op == can_mo_pkg::OP_INIT)
          begin
            init_state <= can_mo_pkg::INIT_WALK;
            init_if    <= cmd_if;
            init_addr  <= 8'h00;
            controller_reset[cmd_if] <= 1'b1;
            disable_all[cmd_if]      <= 1'b1;
          end
        can_mo_pkg::INIT_WALK:
        begin
          init_addr <= init_addr + 8'h01;
          if (init_addr == 8'hff)
            init_state <= can_mo_pkg::INIT_IDLE;
        end
        default:
          init_state <= can_mo_pkg::INIT_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // controller register file
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
      creg_sel <= 9'h000;
    else if (wr && paddr == `REG_CREG_SEL)
      creg_sel <= pwdata[8:0];
  end

  // init walk, then host writes, then arrival number into the interrupt register
  always_ff @(posedge clock)
  begin
    if (busy)
      ctrl_regs[init_if][init_addr] <= init_value(init_addr);
    else if (wr && paddr == `REG_CREG_DATA)
      ctrl_regs[creg_sel[`CREG_IF_BIT]][creg_sel[7:0]] <= pwdata[7:0];
    for (int i = 0; i < 2; i++)
      if (hit[i] && !(busy && init_if == 1'(i)))
        ctrl_regs[i][`CREG_INTERRUPT] <= {4'h0, hit_obj[i]};
  end

  // ----------------------------------------
  // bus read data, latched in the setup cycle
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= 1'b0;
      if (paddr == `REG_CMD || paddr == `REG_EVENT)
        prdata <= {31'h0, event_can};
      else if (paddr == `REG_IDENT)
        prdata <= ident;
      else if (paddr == `REG_RESULT)
        prdata <= result;
      else if (paddr == `REG_STATUS)
        prdata <= {28'h0, cmd_error, tx_valid, busy};
      else if (paddr == `REG_CREG_SEL)
        prdata <= {23'h0, creg_sel};
      else if (paddr == `REG_CREG_DATA)
        prdata <= {24'h0, ctrl_regs[creg_sel[`CREG_IF_BIT]][creg_sel[7:0]]};
      else if (buf_hit)
        prdata <= {24'h0, msg_buffer[buf_idx]};
      else
      begin
        prdata  <= 32'h0;
        pslverr <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_walk;
    busy [*8] ##248 busy ##1 !busy;
  endsequence

  a_init_walk: assert property (@(posedge clock) disable iff (reset)
    cmd_go && cmd_op == can_mo_pkg::OP_INIT |=> s_walk)
    else $error("init walk did not last 256 cycles");
  a_event_fire: assert property (@(posedge clock) disable iff (reset)
    event_can && hit[event_if] && hit_obj[event_if] == event_obj |=> can_event)
    else $error("arrival in watched object gave no event");
  a_event_off: assert property (@(posedge clock) disable iff (reset)
    wr && paddr == `REG_EVENT && !pwdata[0] && !cmd_go |=> !event_can ##1 !can_event)
    else $error("arrival event still active after deselect");
  a_creg_byte: assert property (@(posedge clock) disable iff (reset)
    psel && penable && !pwrite && paddr == `REG_CREG_DATA |-> prdata[31:8] == 24'h0)
    else $error("controller register read not eight bits");
  a_read_once: assert property (@(posedge clock) disable iff (reset)
    cmd_go && cmd_op == can_mo_pkg::OP_READ && !view[cmd_if].new_data
    |=> result == `NO_MESSAGE)
    else $error("read without new message did not report none");
endmodule
`default_nettype wire

// ### core/can_object_bank.sv
// bank of message objects for one interface
`default_nettype none
module can_object_bank #(
  parameter int NOBJ = 15
) (
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic                   disable_all,
  input  wire logic                   cfg_write,
  input  wire logic [3:0]             cfg_obj,
  input  wire can_mo_pkg::obj_mode_t  cfg_mode,
  input  wire logic [28:0]            cfg_id,
  input  wire logic                   cfg_ext,
  input  wire logic [3:0]             rd_obj,
  input  wire logic                   rd_take,
  input  wire logic                   rx_valid,
  input  wire can_mo_pkg::can_frame_t rx_frame,
  output can_mo_pkg::obj_view_t       sel_view,
  output logic                        hit,
  output logic [3:0]                  hit_obj
);
  can_mo_pkg::obj_view_t obj [NOBJ];
  logic [NOBJ-1:0]       match;
  logic [NOBJ-1:0]       store;
  logic [NOBJ-1:0]       new_vec;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // per object state
  // ----------------------------------------
  for (genvar k = 0; k < NOBJ; k++)
  begin : g_obj
    // identifier compare honours the length select
    assign match[k] = rx_valid && obj[k].mode == can_mo_pkg::OBJ_RX
                      && obj[k].ext == rx_frame.ext
                      && (obj[k].ext ? obj[k].id == rx_frame.id
                          : obj[k].id[10:0] == rx_frame.id[10:0]);
    assign new_vec[k] = obj[k].new_data;

    // configuration, storage and new-data flag; a store beats a read clear
    always_ff @(posedge clock)
    begin
      if (reset || disable_all)
      begin
        obj[k] <= '0;
      end
      else if (cfg_write && cfg_obj == 4'(k + 1))
      begin
        obj[k].mode     <= cfg_mode;
        obj[k].ext      <= cfg_ext;
        obj[k].id       <= cfg_ext ? cfg_id : {18'h0, cfg_id[10:0]};
        obj[k].new_data <= 1'b0;
      end
      else if (store[k])
      begin
        obj[k].len      <= rx_frame.len;
        obj[k].data     <= rx_frame.data;
        obj[k].new_data <= 1'b1;
      end
      else if (rd_take && rd_obj == 4'(k + 1))
      begin
        obj[k].new_data <= 1'b0;
      end
    end
  end

  // lowest numbered matching object takes the frame
  assign store = match & (~match + NOBJ'(1));
  assign hit   = |store;

  // object number of the winner
  always_comb
  begin
    hit_obj = 4'h0;
    for (int k = NOBJ - 1; k >= 0; k--)
      if (store[k])
        hit_obj = 4'(k + 1);
  end

  // view of the object that the command names
  always_comb
  begin
    sel_view = '0;
    if (rd_obj != 4'h0 && rd_obj <= 4'(NOBJ))
      sel_view = obj[rd_obj - 4'h1];
  end

  a_ignore_other: assert property (
    rx_valid && match == '0 && !disable_all && !cfg_write && !rd_take
    |=> $stable(new_vec))
    else $error("non-matching frame changed an object");
  a_store_flags: assert property (
    hit && !disable_all && !cfg_write |=> (new_vec & $past(store)) == $past(store))
    else $error("stored frame did not raise its new-data flag");
endmodule
`default_nettype wire

// ### dv/can_node_model.sv
// frame-level stand-in for the other nodes on both buses
`default_nettype none
module can_node_model (
  input  wire logic                         clock,
  input  wire logic [1:0]                   tx_valid,
  input  wire can_mo_pkg::can_frame_t [1:0] tx_frame,
  input  wire logic [7:0]                   slow,
  output logic [1:0]                        tx_ready,
  output logic [1:0]                        rx_valid,
  output can_mo_pkg::can_frame_t [1:0]      rx_frame,
  output can_mo_pkg::can_frame_t            last_tx,
  output logic [7:0]                        n_tx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] stall [2] = '{8'h00, 8'h00};
  initial
  begin
    tx_ready = '0;
    rx_valid = '0;
    rx_frame = '0;
    last_tx  = '0;
    n_tx     = '0;
  end
  // one frame for one cycle, then a changed value so stale data is never seen
  task automatic send(input int i, input can_mo_pkg::can_frame_t f);
    @(posedge clock);
    rx_valid[i] <= 1'b1;
    rx_frame[i] <= f;
    @(posedge clock);
    rx_valid[i] <= 1'b0;
    rx_frame[i] <= ~f;
  endtask
  // accept a pending frame after slow cycles of stall
  always @(posedge clock)
    for (int i = 0; i < 2; i++)
    begin
      if (tx_valid[i] && tx_ready[i])
      begin
        last_tx     <= tx_frame[i];
        n_tx        <= n_tx + 8'h01;
        tx_ready[i] <= 1'b0;
        stall[i]    <= 8'h00;
      end
      else
      begin
        tx_ready[i] <= tx_valid[i] && (stall[i] >= slow);
        stall[i]    <= tx_valid[i] ? stall[i] + 8'h01 : 8'h00;
      end
    end
endmodule
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the message object front end
`include "can_mo_consts.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                         clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]                   paddr = '0, slow = '0, n_tx;
  logic [31:0]                  pwdata = '0, prdata, rd;
  logic                         pready, pslverr, can_event, perr, ext;
  logic [1:0]                   rx_valid, tx_valid, tx_ready, controller_reset;
  can_mo_pkg::can_frame_t [1:0] rx_frame, tx_frame;
  can_mo_pkg::can_frame_t       last_tx;
  logic [28:0]                  id;
  logic [3:0]                   obj, cnt;
  logic [63:0]                  data, ed;
  logic [7:0]                   nt;
  int n_errors = 0, samples_checked = 0, seed = 37, n_event = 0, n_creset = 0, i;
  logic [7:0] regs [9] = '{8'h00, 8'h01, 8'h06, 8'h0e, 8'h1f, 8'h2f, 8'h3f, 8'h4f, 8'h5f};
  logic [7:0] vals [9] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, `BITTIME0_1MBIT,
                           `BITTIME1_1MBIT, 8'h00};

  can_mo_front u_can_mo_front (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_valid, .rx_frame, .tx_valid, .tx_frame, .tx_ready,
    .controller_reset, .can_event);
  can_node_model u_can_node_model (.clock, .tx_valid, .tx_frame, .slow, .tx_ready,
    .rx_valid, .rx_frame, .last_tx, .n_tx);

  always #20 clock = ~clock;
  // count one-cycle pulses
  always @(posedge clock)
  begin
    n_event  += (can_event === 1'b1);
    n_creset += (!reset && controller_reset !== 2'b00); // unknown before first reset edge
  end

  // ----------------------------------------
  // bus tasks and expectations
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input int c, input logic [3:0] o, input can_mo_pkg::cmd_op_t op);
    apb(1, `REG_CMD, 32'({op, 3'b000, c[0], o}));
  endtask
  task automatic creg(input int c, input logic [7:0] n);
    apb(1, `REG_CREG_SEL, 32'({c[0], n}));
    apb(0, `REG_CREG_DATA, 0);
  endtask
  function automatic logic [63:0] keep(input logic [63:0] d, input logic [3:0] n);
    return (n >= 8) ? d : d & ((64'h1 << (8 * n)) - 64'h1);
  endfunction
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #(40ns * 40000);
    n_errors++;
    end_of_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    apb(0, `REG_RESULT, 0);
    check("result", rd, `NO_MESSAGE);
    apb(0, 8'h44, 0);
    check("slverr", 32'(perr), 1);
    for (int c = 0; c < 2; c++)
    begin
      cmd(c, 0, can_mo_pkg::OP_INIT);
      apb(0, `REG_STATUS, 0);
      check("busy", rd & 1, 1);
      // a command while init runs is refused and flags the error
      cmd(c, 1, can_mo_pkg::OP_EN_RX);
      apb(0, `REG_STATUS, 0);
      check("busy refuse", rd & 9, 9);
      apb(1, `REG_STATUS, 8);
      for (int p = 0; p < 150 && rd[0] !== 1'b0; p++) apb(0, `REG_STATUS, 0);
      check("busy clear", rd & 9, 0);
      check("ctl reset", n_creset, c + 1);
      for (int r = 0; r < 9; r++)
      begin
        creg(c, regs[r]);
        check("creg", rd, 32'(vals[r]));
      end
      // host write of a controller register reads back
      nt = 8'($random(seed));
      apb(1, `REG_CREG_DATA, 32'(nt));
      apb(0, `REG_CREG_DATA, 0);
      check("creg write", rd, 32'(nt));
    end
    for (int k = 0; k < 6; k++)
    begin
      i = k % 2;
      obj = 4'(k + 1);
      ext = 1'($random(seed));
      id = 29'($random(seed));
      if (!ext) id[28:11] = '0;
      data = {$random(seed), $random(seed)};
      cnt = (k == 0) ? 4'h8 : 4'($unsigned($random(seed)) % 9);
      apb(1, `REG_IDENT, {ext, 2'b00, id});
      cmd(i, obj, can_mo_pkg::OP_EN_RX);
      if (k == 0) cmd(i, obj, can_mo_pkg::OP_EN_EVENT);
      u_can_node_model.send(i, {id + 29'h1, ext, cnt, data});
      u_can_node_model.send(i, {id, ~ext, cnt, data});
      cmd(i, obj, can_mo_pkg::OP_READ);
      apb(0, `REG_RESULT, 0);
      check("filtered", rd, `NO_MESSAGE);
      u_can_node_model.send(i, {id, ext, cnt, data});
      // id zero equals the idle contents of the lowest disabled object, which does not match it
      u_can_node_model.send(i, {29'h0, 1'b0, cnt, data});
      cmd(i, 4'(2 - i), can_mo_pkg::OP_READ);
      apb(0, `REG_RESULT, 0);
      check("disabled", rd, `NO_MESSAGE);
      cmd(i, obj, can_mo_pkg::OP_READ);
      apb(0, `REG_RESULT, 0);
      check("rx id", rd, 32'(id));
      for (int n = 1; n <= 9; n++)
      begin
        apb(0, `REG_BUF_BASE + 8'(4 * (n - 1)), 0);
        if (n == 9 || n <= cnt)
          check("buffer", rd, (n == 9) ? 32'(cnt) : 32'(data[8 * (n - 1) +: 8]));
      end
      cmd(i, obj, can_mo_pkg::OP_READ);
      apb(0, `REG_RESULT, 0);
      check("reread", rd, `NO_MESSAGE);
      creg(i, `CREG_INTERRUPT);
      check("int reg", rd, 32'(obj));
      if (k == 0)
      begin
        check("event", n_event, 1);
        apb(1, `REG_EVENT, 0);
        u_can_node_model.send(i, {id, ext, cnt, data});
        repeat (2) @(posedge clock);
        check("no event", n_event, 1);
      end
      cmd(i, 4'(15 - k), can_mo_pkg::OP_TRANSMIT);
      apb(0, `REG_STATUS, 0);
      check("tx refused", rd & 8, 8);
      apb(1, `REG_STATUS, 8);
      cmd(i, 4'(15 - k), can_mo_pkg::OP_EN_TX);
      for (int n = 1; n <= 9; n++)
        apb(1, `REG_BUF_BASE + 8'(4 * (n - 1)),
            (n == 9) ? 32'(cnt) : 32'(data[8 * (n - 1) +: 8]));
      slow <= 8'($unsigned($random(seed)) % 8);
      nt = n_tx;
      cmd(i, 4'(15 - k), can_mo_pkg::OP_TRANSMIT);
      for (int p = 0; p < 40 && n_tx == nt; p++) @(posedge clock);
      check("tx done", 32'(n_tx), 32'(nt + 8'h01));
      ed = keep(data, cnt);
      check("tx id", 32'(last_tx.id), 32'(id));
      check("tx len", 32'({last_tx.ext, last_tx.len}), 32'({ext, cnt}));
      check("tx lo", last_tx.data[31:0], ed[31:0]);
      check("tx hi", last_tx.data[63:32], ed[63:32]);
    end
    end_of_test();
  end
endmodule
`default_nettype wire

// ### include/can_mo_consts.svh
// offsets, field positions, reset values and counts for the message object front end
`ifndef CAN_MO_CONSTS_SVH
`define CAN_MO_CONSTS_SVH

// ----------------------------------------
// bus register byte addresses
// ----------------------------------------
`define REG_CMD        8'h00
`define REG_IDENT      8'h04
`define REG_RESULT     8'h08
`define REG_STATUS     8'h0c
`define REG_EVENT      8'h10
`define REG_CREG_SEL   8'h14
`define REG_CREG_DATA  8'h18
`define REG_BUF_BASE   8'h20
`define REG_BUF_LAST   8'h40

// ----------------------------------------
// field positions
// ----------------------------------------
`define CMD_IF_BIT     4
`define CMD_OP_LSB     8
`define IDENT_EXT_BIT  31
`define CREG_IF_BIT    8
`define STAT_BUSY_BIT  0
`define STAT_TX_LSB    1
`define STAT_ERR_BIT   3

// ----------------------------------------
// controller register map and init values
// ----------------------------------------
`define CREG_CONTROL    8'h00
`define CREG_STATUS     8'h01
`define CREG_INTERRUPT  8'h5f
`define CREG_MASK_FIRST 8'h06
`define CREG_MASK_LAST  8'h0e
`define CREG_CLKOUT     8'h1f
`define CREG_BUSCFG     8'h2f
`define CREG_BITTIME0   8'h3f
`define CREG_BITTIME1   8'h4f
`define MASK_EXACT      8'hff
`define BITTIME0_1MBIT  8'h00
`define BITTIME1_1MBIT  8'h14
`define CREG_CLEAR      8'h00

// ----------------------------------------
// misc values
// ----------------------------------------
`define NO_MESSAGE      32'hffffffff
`define BUF_LEN_ENTRY   9
`define MAX_DATA_BYTES  8'h08
`define STD_ID_BITS     11

`endif

// ### include/can_mo_pkg.sv
// types shared by the message object front end
`default_nettype none
package can_mo_pkg;

  // one frame on the frame-level link
  typedef struct packed {
    logic [28:0] id;
    logic        ext;
    logic [3:0]  len;
    logic [63:0] data;
  } can_frame_t;

  typedef enum logic [1:0] {
    OBJ_OFF = 2'b00,
    OBJ_RX  = 2'b01,
    OBJ_TX  = 2'b10
  } obj_mode_t;

  typedef enum logic [2:0] {
    OP_NONE     = 3'b000,
    OP_EN_RX    = 3'b001,
    OP_EN_TX    = 3'b010,
    OP_TRANSMIT = 3'b011,
    OP_READ     = 3'b100,
    OP_INIT     = 3'b101,
    OP_EN_EVENT = 3'b110
  } cmd_op_t;

  typedef enum logic {
    INIT_IDLE = 1'b0,
    INIT_WALK = 1'b1
  } init_state_t;

  // contents of one object as seen by the command logic
  typedef struct packed {
    obj_mode_t   mode;
    logic        ext;
    logic [28:0] id;
    logic        new_data;
    logic [3:0]  len;
    logic [63:0] data;
  } obj_view_t;

endpackage
`default_nettype wire
